// ### common/ctp_pkg.sv
// shared constants and carrier types of the cascadable timer pair
package ctp_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int CTP_CNT_W = 8;
  localparam logic [7:0] CTP_CNT_ZERO = 8'h00;
  localparam logic [7:0] CTP_CNT_ONE = 8'h01;
  localparam logic [7:0] CTP_CNT_MAX = 8'hFF;
  localparam logic [3:0] CTP_DIV_RST = 4'h0;
  localparam logic [3:0] CTP_DIV_ONE = 4'h1;

  // ----------------------------------------------------------------
  // count clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CTP_CLK_SYS = 3'h0;
  localparam logic [2:0] CTP_CLK_X2 = 3'h1;
  localparam logic [2:0] CTP_CLK_DIV2 = 3'h2;
  localparam logic [2:0] CTP_CLK_DIV4 = 3'h3;
  localparam logic [2:0] CTP_CLK_DIV8 = 3'h4;
  localparam logic [2:0] CTP_CLK_DIV16 = 3'h5;

  // ----------------------------------------------------------------
  // operating mode field codes, held per timer
  // ----------------------------------------------------------------
  localparam logic [1:0] CTP_MODE_DISCRETE = 2'h0;
  localparam logic [1:0] CTP_MODE_CASCADE = 2'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic high_timer_run_enable;
    logic low_timer_run_enable;
    logic timer_output_enable;
    logic [1:0] high_mode;
    logic [1:0] low_mode;
    logic [2:0] high_clock_select;
    logic high_count_low_match;
    logic [2:0] low_clock_select;
    logic [7:0] high_compare_value;
    logic [7:0] low_compare_value;
  } ctp_cfg_t;

  typedef struct packed {
    logic [7:0] high_byte_counter;
    logic [7:0] low_byte_counter;
    logic cascade_active;
    logic mode_error;
    logic clock_error;
  } ctp_status_t;

endpackage

// ### hw/ctp_timer.sv
// cascadable 8-bit timer pair with square-wave output
//
// What this block does
// [RQ1] 8-bit interval mode raises match interrupt every compare plus one ticks.
// [RQ2] 8-bit square wave toggles output pin when low counter equals compare.
// [RQ3] low timer match clears counter, keeps counting, pulses interrupt same cycle.
// [RQ4] clearing low run enable forces square-wave level to zero.
// [RQ5] output pin starts low once output enable is set. A low match in the enabling cycle toggles it high at once.
// [RQ6] cascade forms 16-bit counter, high byte first timer, carry low to high.
// [RQ7] cascade starts and clears only from low run enable, high ignored.
// [RQ8] cascade full match clears both bytes, raises only low interrupt.
// [RQ9] 16-bit square wave toggles only on simultaneous match of both bytes.
// [RQ10] 16-bit period is 256 times high compare plus low plus one.
// [RQ11] software stops, loads, selects mode, clock, enables output, then starts.
// [RQ12] software sets up 16-bit interval in order, starts with low run.
// [RQ13] software stops counter before changing the count clock selection.
// [RQ14] clock select picks sys, x2, /2, /4, /8, /16; others prohibited. x2 ticks once per clock, the same as sys.
// [RQ15] cascade only when both mode fields hold cascade; mismatch prohibited.
// [RQ16] high timer can count low timer match as its clock.
// [RQ17] counters step once per enabled tick and hold zero while stopped.
`timescale 1ns/100ps

module ctp_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // configuration
  input wire ctp_pkg::ctp_cfg_t i_cfg,
  // pin port setup
  input wire logic i_pin_direction_bit,
  input wire logic i_shared_output_pin,
  // timer output pin
  output logic o_timer_output_pin,
  output logic o_timer_output_pin_oe,
  // events
  output logic o_low_timer_match_irq,
  output logic o_high_timer_match_irq,
  // status
  output ctp_pkg::ctp_status_t o_status
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] div;
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  logic level;
  logic low_irq;
  logic high_irq;
  logic pin_out;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire logic discrete = (i_cfg.high_mode == ctp_pkg::CTP_MODE_DISCRETE)
    && (i_cfg.low_mode == ctp_pkg::CTP_MODE_DISCRETE);
  wire logic cascade = (i_cfg.high_mode == ctp_pkg::CTP_MODE_CASCADE)
    && (i_cfg.low_mode == ctp_pkg::CTP_MODE_CASCADE); // RQ15
  wire logic mode_bad = !discrete && !cascade; // RQ15

  wire logic low_run = i_cfg.low_timer_run_enable && !mode_bad;
  // cascade ignores the high run enable
  wire logic high_run = cascade ? low_run
    : (i_cfg.high_timer_run_enable && discrete); // RQ7

  // ----------------------------------------------------------------
  // count clock prescaler
  // ----------------------------------------------------------------
  function automatic logic sel_tick(input logic [2:0] sel, input logic [3:0] d);
    logic t;
    t = 1'b0;
    case (sel)
      ctp_pkg::CTP_CLK_SYS: t = 1'b1;
      ctp_pkg::CTP_CLK_X2: t = 1'b1;
      ctp_pkg::CTP_CLK_DIV2: t = d[0];
      ctp_pkg::CTP_CLK_DIV4: t = &d[1:0];
      ctp_pkg::CTP_CLK_DIV8: t = &d[2:0];
      ctp_pkg::CTP_CLK_DIV16: t = &d;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  wire logic low_clk_bad = (i_cfg.low_clock_select > ctp_pkg::CTP_CLK_DIV16); // RQ14
  wire logic high_clk_bad = (i_cfg.high_clock_select > ctp_pkg::CTP_CLK_DIV16)
    && !i_cfg.high_count_low_match;
  wire logic low_tick = low_run && sel_tick(i_cfg.low_clock_select, div); // RQ14
  wire logic [3:0] next_div = div + ctp_pkg::CTP_DIV_ONE;

  // ----------------------------------------------------------------
  // match and next counter values
  // ----------------------------------------------------------------
  wire logic low_match = (low_cnt == i_cfg.low_compare_value);
  wire logic high_match = (high_cnt == i_cfg.high_compare_value);
  wire logic full_match = low_match && high_match; // RQ9
  // low timer event: 8-bit match, or 16-bit full match in cascade
  wire logic low_evt = low_tick && (cascade ? full_match : low_match); // RQ3 RQ8 RQ10
  // high timer clock: low match signal or its own prescaler
  wire logic high_tick = high_run && !cascade && (i_cfg.high_count_low_match ? low_evt
    : sel_tick(i_cfg.high_clock_select, div)); // RQ16
  wire logic high_evt = high_tick && high_match;
  wire logic low_carry = low_tick && !low_evt && (low_cnt == ctp_pkg::CTP_CNT_MAX);

  wire logic [7:0] next_low_cnt = !low_run ? ctp_pkg::CTP_CNT_ZERO // RQ17
    : low_evt ? ctp_pkg::CTP_CNT_ZERO // RQ3
    : low_tick ? low_cnt + ctp_pkg::CTP_CNT_ONE // RQ1
    : low_cnt;
  wire logic [7:0] next_high_cnt = !high_run ? ctp_pkg::CTP_CNT_ZERO // RQ7
    : cascade ? (low_evt ? ctp_pkg::CTP_CNT_ZERO // RQ8
      : low_carry ? high_cnt + ctp_pkg::CTP_CNT_ONE // RQ6
      : high_cnt)
    : high_evt ? ctp_pkg::CTP_CNT_ZERO
    : high_tick ? high_cnt + ctp_pkg::CTP_CNT_ONE
    : high_cnt;

  // ----------------------------------------------------------------
  // square-wave level and pin
  // ----------------------------------------------------------------
  wire logic next_level = (!i_cfg.low_timer_run_enable || !i_cfg.timer_output_enable) ? 1'b0 // RQ4 RQ5
    : low_evt ? !level // RQ2 RQ9
    : level;
  wire logic next_pin_out = i_cfg.timer_output_enable ? next_level : i_shared_output_pin;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div <= ctp_pkg::CTP_DIV_RST;
      low_cnt <= ctp_pkg::CTP_CNT_ZERO;
      high_cnt <= ctp_pkg::CTP_CNT_ZERO;
      level <= 1'b0;
      pin_out <= 1'b0;
      low_irq <= 1'b0;
      high_irq <= 1'b0;
    end
    else
    begin
      div <= next_div;
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
      level <= next_level;
      pin_out <= next_pin_out;
      low_irq <= low_evt; // RQ3
      high_irq <= high_evt && !cascade; // RQ8
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_timer_output_pin = pin_out;
  assign o_timer_output_pin_oe = !i_pin_direction_bit;
  assign o_low_timer_match_irq = low_irq;
  assign o_high_timer_match_irq = high_irq;
  assign o_status = ctp_pkg::ctp_status_t'{
    high_byte_counter: high_cnt,
    low_byte_counter: low_cnt,
    cascade_active: cascade,
    mode_error: mode_bad,
    clock_error: low_clk_bad || high_clk_bad
  };

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_irq_clears_low: assert property (@(posedge i_clk) disable iff (i_rst)
    o_low_timer_match_irq |-> (low_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("low irq without cleared counter"); // RQ3

  a_low_step_one: assert property (@(posedge i_clk) disable iff (i_rst)
    (low_run && low_tick && !low_evt) |=> (low_cnt == 8'($past(low_cnt) + 8'h01)))
    else $error("low counter did not step by one"); // RQ1

  a_stop_holds_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    !low_run |=> (low_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("stopped low counter not zero"); // RQ17

  a_stop_forces_low: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_cfg.low_timer_run_enable |=> !level)
    else $error("square level not forced low"); // RQ4

  a_out_off_low: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_cfg.timer_output_enable ##1 i_cfg.timer_output_enable && !low_evt) |=> !level)
    else $error("output did not start low"); // RQ5

  a_toggle_on_match: assert property (@(posedge i_clk) disable iff (i_rst)
    (low_evt && i_cfg.timer_output_enable && i_cfg.low_timer_run_enable)
    |=> (level != $past(level)))
    else $error("no toggle on match"); // RQ2

  a_no_partial_toggle: assert property (@(posedge i_clk) disable iff (i_rst)
    (cascade && low_tick && low_match && !high_match) |=> $stable(level))
    else $error("toggle on partial 16-bit match"); // RQ9

  a_cascade_carry: assert property (@(posedge i_clk) disable iff (i_rst)
    (cascade && low_carry) |=> (low_cnt == ctp_pkg::CTP_CNT_ZERO)
    && (high_cnt == 8'($past(high_cnt) + 8'h01)))
    else $error("cascade carry wrong"); // RQ6

  a_cascade_ignore_high: assert property (@(posedge i_clk) disable iff (i_rst)
    (cascade && !i_cfg.low_timer_run_enable) |=> (high_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("cascade high byte ran without low run"); // RQ7

  a_cascade_irq_only_low: assert property (@(posedge i_clk) disable iff (i_rst)
    (cascade && low_evt) |=> o_low_timer_match_irq && !o_high_timer_match_irq
    && (high_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("cascade match irq or clear wrong"); // RQ8

  a_bad_clock_stall: assert property (@(posedge i_clk) disable iff (i_rst)
    low_clk_bad |-> !low_tick)
    else $error("prohibited clock code ticked"); // RQ14

  a_bad_mode_stop: assert property (@(posedge i_clk) disable iff (i_rst)
    mode_bad |=> (low_cnt == ctp_pkg::CTP_CNT_ZERO) && (high_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("prohibited mode counted"); // RQ15

  a_high_from_match: assert property (@(posedge i_clk) disable iff (i_rst)
    (discrete && high_run && i_cfg.high_count_low_match) |-> (high_tick == low_evt))
    else $error("high timer not clocked by low match"); // RQ16

  a_irq_from_event: assert property (@(posedge i_clk) disable iff (i_rst)
    low_evt |=> o_low_timer_match_irq)
    else $error("low match event gave no irq"); // RQ3

  a_no_spurious_irq: assert property (@(posedge i_clk) disable iff (i_rst)
    !low_evt |=> !o_low_timer_match_irq)
    else $error("low irq without match event"); // RQ1

  a_high_irq_event: assert property (@(posedge i_clk) disable iff (i_rst)
    (high_evt && !cascade) |=> o_high_timer_match_irq)
    else $error("high match event gave no irq"); // RQ1

  a_cascade_no_high: assert property (@(posedge i_clk) disable iff (i_rst)
    cascade |=> !o_high_timer_match_irq)
    else $error("high irq raised in cascade"); // RQ8

  a_low_match_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (!cascade && low_tick && low_match) |=> (low_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("low counter not cleared on match"); // RQ3

  a_cascade_full_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (cascade && low_evt) |=> (low_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("low byte not cleared on full match"); // RQ8

  a_cascade_low_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (cascade && low_tick && !full_match && (low_cnt != ctp_pkg::CTP_CNT_MAX))
    |=> (low_cnt == 8'($past(low_cnt) + 8'h01)) && $stable(high_cnt))
    else $error("cascade low byte step wrong"); // RQ6

  a_idle_tick_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    (low_run && !low_tick) |=> $stable(low_cnt))
    else $error("low counter moved without tick"); // RQ17

  a_high_stop_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    !high_run |=> (high_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("stopped high counter not zero"); // RQ17

  a_high_step_one: assert property (@(posedge i_clk) disable iff (i_rst)
    (!cascade && high_tick && !high_match) |=> (high_cnt == 8'($past(high_cnt) + 8'h01)))
    else $error("high counter did not step by one"); // RQ17

  a_high_match_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (!cascade && high_evt) |=> (high_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("high counter not cleared on match"); // RQ1

  a_discrete_high_off: assert property (@(posedge i_clk) disable iff (i_rst)
    (discrete && !i_cfg.high_timer_run_enable) |=> (high_cnt == ctp_pkg::CTP_CNT_ZERO))
    else $error("discrete high counter ran while off"); // RQ17

  a_cascade_level_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (cascade && !low_evt && i_cfg.low_timer_run_enable && i_cfg.timer_output_enable)
    |=> $stable(level))
    else $error("cascade level moved without full match"); // RQ9

  a_pin_follows_level: assert property (@(posedge i_clk) disable iff (i_rst)
    i_cfg.timer_output_enable |=> (o_timer_output_pin == level))
    else $error("pin does not show square level"); // RQ2

  a_stop_clears_pin: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_cfg.low_timer_run_enable && i_cfg.timer_output_enable) |=> !o_timer_output_pin)
    else $error("pin not low after stop"); // RQ4

  a_bad_clock_high: assert property (@(posedge i_clk) disable iff (i_rst)
    high_clk_bad |-> !high_tick)
    else $error("prohibited high clock code ticked"); // RQ14

  a_bad_mode_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    mode_bad |=> !o_low_timer_match_irq && !o_high_timer_match_irq)
    else $error("irq raised in prohibited mode"); // RQ15

  a_sys_every_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
    (low_run && (i_cfg.low_clock_select == ctp_pkg::CTP_CLK_SYS)) |-> low_tick)
    else $error("system clock code missed a tick"); // RQ14

  a_x2_every_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
    (low_run && (i_cfg.low_clock_select == ctp_pkg::CTP_CLK_X2)) |-> low_tick)
    else $error("x2 clock code missed a tick"); // RQ14

  a_div2_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
    (low_tick && (i_cfg.low_clock_select == ctp_pkg::CTP_CLK_DIV2)) |=> !low_tick)
    else $error("divide by two ticked twice in a row"); // RQ14

  a_div16_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
    (low_tick && (i_cfg.low_clock_select == ctp_pkg::CTP_CLK_DIV16)) |=> !low_tick)
    else $error("divide by sixteen ticked twice in a row"); // RQ14

endmodule // ctp_timer

// ### tb/ctp_load.sv
// external load model counting rising levels on the timer output pin
`timescale 1ns/100ps

module ctp_load (
  // clock
  input wire logic i_clk,
  // resolved pin wire
  input wire logic i_pin,
  // observed rising levels
  output int o_rises
);
  logic last = 1'b0;
  int rises = 0;
  assign o_rises = rises;
  always @(posedge i_clk)
  begin
    if (i_pin === 1'b1 && last !== 1'b1)
      rises <= rises + 1;
    last <= i_pin;
  end
endmodule // ctp_load

// ### tb/test_cascadable_timer_pair_square_wave.sv
// self-checking bench for the cascadable timer pair
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end

module test_cascadable_timer_pair_square_wave;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  ctp_pkg::ctp_cfg_t cfg = '0;
  logic pin, oe, irq_lo, irq_hi, lvl;
  logic pdir = 1'b0;
  logic latch = 1'b0;
  ctp_pkg::ctp_status_t st;
  wire pin_wire = oe ? pin : 1'b0;
  int rises, r0, n, n_fail = 0, samples_checked = 0;
  int div_tab[6] = '{1, 1, 2, 4, 8, 16};
  logic [7:0] cmp_tab[3] = '{8'h00, 8'h02, 8'hFF};

  always #50 i_clk = ~i_clk;

  ctp_timer i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cfg(cfg), .i_pin_direction_bit(pdir),
    .i_shared_output_pin(latch), .o_timer_output_pin(pin), .o_timer_output_pin_oe(oe),
    .o_low_timer_match_irq(irq_lo), .o_high_timer_match_irq(irq_hi), .o_status(st));
  ctp_load i_load (.i_clk(i_clk), .i_pin(pin_wire), .o_rises(rises));

  task automatic final_report;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wait_irq(input bit hi, input int lim, output int cnt);
    cnt = 0;
    @(negedge i_clk);
    while (((hi ? irq_hi : irq_lo) !== 1'b1) && cnt < lim)
    begin
      cnt++;
      @(negedge i_clk);
    end
  endtask

  task automatic period(input bit hi, input int exp);
    wait_irq(hi, 3000, n);
    wait_irq(hi, 3000, n);
    `CHK("irq period", exp, n + 1)
  endtask

  // stop, load, select mode and clock, then run
  task automatic start(input logic [2:0] sel, input logic [1:0] mode, input logic [7:0] hc, input logic [7:0] lc);
    @(negedge i_clk);
    cfg.low_timer_run_enable = 1'b0;
    cfg.high_timer_run_enable = 1'b0;
    @(negedge i_clk);
    cfg.low_compare_value = lc;
    cfg.high_compare_value = hc;
    cfg.low_mode = mode;
    cfg.high_mode = mode;
    cfg.low_clock_select = sel;
    @(negedge i_clk);
    cfg.low_timer_run_enable = 1'b1;
  endtask

  initial
  begin
    repeat (10000) @(posedge i_clk);
    n_fail++;
    final_report();
  end

  initial
  begin
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    // ----------------------------------------------------------------
    // 8-bit interval and count clocks
    // ----------------------------------------------------------------
    foreach (cmp_tab[k])
    begin
      start(ctp_pkg::CTP_CLK_SYS, ctp_pkg::CTP_MODE_DISCRETE, 8'h00, cmp_tab[k]);
      period(1'b0, int'(cmp_tab[k]) + 1);
      `CHK("low count at match", 8'h00, st.low_byte_counter)
    end
    foreach (div_tab[c])
    begin
      start(3'(c), ctp_pkg::CTP_MODE_DISCRETE, 8'h00, 8'h03);
      period(1'b0, 4 * div_tab[c]);
    end
    start(3'h6, ctp_pkg::CTP_MODE_DISCRETE, 8'h00, 8'h03);
    wait_irq(1'b0, 40, n);
    `CHK("no irq on bad clock", 40, n)
    `CHK("clock error", 1'b1, st.clock_error)
    // ----------------------------------------------------------------
    // 8-bit square wave and stop
    // ----------------------------------------------------------------
    cfg.timer_output_enable = 1'b1;
    start(ctp_pkg::CTP_CLK_SYS, ctp_pkg::CTP_MODE_DISCRETE, 8'h00, 8'h03);
    r0 = rises;
    `CHK("pin before start", 1'b0, pin)
    `CHK("pin driven", 1'b1, oe)
    wait_irq(1'b0, 3000, n);
    `CHK("first toggle", 1'b1, pin)
    wait_irq(1'b0, 3000, n);
    `CHK("half period", 4, n + 1)
    `CHK("second toggle", 1'b0, pin)
    `CHK("load rises", 1, rises - r0)
    wait_irq(1'b0, 3000, n);
    cfg.low_timer_run_enable = 1'b0;
    @(negedge i_clk);
    `CHK("pin after stop", 1'b0, pin)
    `CHK("count after stop", 8'h00, st.low_byte_counter)
    // ----------------------------------------------------------------
    // cascade with square wave, high run left off
    // ----------------------------------------------------------------
    start(ctp_pkg::CTP_CLK_SYS, ctp_pkg::CTP_MODE_CASCADE, 8'h01, 8'h02);
    `CHK("cascade active", 1'b1, st.cascade_active)
    wait_irq(1'b1, 600, n);
    `CHK("no high irq", 600, n)
    period(1'b0, 259);
    `CHK("both bytes cleared", 16'h0000, {st.high_byte_counter, st.low_byte_counter})
    lvl = pin;
    wait_irq(1'b0, 3000, n);
    `CHK("wide toggle", ~lvl, pin)
    // ----------------------------------------------------------------
    // mismatched modes, then high counts low matches
    // ----------------------------------------------------------------
    cfg.low_mode = ctp_pkg::CTP_MODE_DISCRETE;
    repeat (3) @(negedge i_clk);
    `CHK("mode error", 1'b1, st.mode_error)
    `CHK("held count", 8'h00, st.low_byte_counter)
    cfg.high_count_low_match = 1'b1;
    start(ctp_pkg::CTP_CLK_SYS, ctp_pkg::CTP_MODE_DISCRETE, 8'h02, 8'h01);
    cfg.high_timer_run_enable = 1'b1;
    period(1'b1, 6);
    // port latch shown when timer output is off, then pin released
    cfg.timer_output_enable = 1'b0;
    latch = 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK("latch on pin", 1'b1, pin)
    pdir = 1'b1;
    @(negedge i_clk);
    `CHK("pin released", 1'b0, oe)
    final_report();
  end
endmodule // test_cascadable_timer_pair_square_wave
